// ==== rtl/lvm_meter.sv ====
`timescale 1ns/1ns
module lvm_meter
    import lvm_pkg::*;
(
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // command port: command byte with write data in the same cycle
    input wire logic I_CMD_VALID,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_WR_DATA,
    // pcm samples of the four channels, compressed code in the low byte
    input wire logic [15:0] I_PCM_CH1,
    input wire logic [15:0] I_PCM_CH2,
    input wire logic [15:0] I_PCM_CH3,
    input wire logic [15:0] I_PCM_CH4,
    // read answer
    output logic O_RD_VALID,
    output logic [7:0] O_RD_DATA
);

    // register state
    logic [LVM_CTRL_W-1:0] ctrl_q;
    logic [7:0] win_q;
    logic [7:1] res_lo_q;
    logic [7:0] res_hi_q;
    logic ready_q;
    logic ready_d;
    logic [LVM_FRAME_CNT_W-1:0] frame_cnt_q;
    logic tick_q;
    logic acc_done;
    logic [15:0] acc_result;
    logic [7:0] rd_data_d;

    // command decode; bit 7 splits read from write
    wire logic cmd_wr_w = I_CMD[LVM_CMD_WR_BIT];
    wire logic rd_lo_w = I_CMD_VALID && (I_CMD == LVM_CMD_RD_RES_LO);
    wire logic rd_hi_w = I_CMD_VALID && (I_CMD == LVM_CMD_RD_RES_HI);
    wire logic rd_win_w = I_CMD_VALID && (I_CMD == LVM_CMD_RD_WIN);
    wire logic wr_win_w = I_CMD_VALID && cmd_wr_w && (I_CMD == LVM_CMD_WR_WIN);
    wire logic rd_ctrl_w = I_CMD_VALID && (I_CMD == LVM_CMD_RD_CTRL);
    wire logic wr_ctrl_w = I_CMD_VALID && cmd_wr_w && (I_CMD == LVM_CMD_WR_CTRL);
    wire logic rd_any_w = rd_lo_w || rd_hi_w || rd_win_w || rd_ctrl_w;

    // control fields
    wire logic meter_on = ctrl_q[LVM_CTRL_ON_BIT];
    wire logic linear_sel = ctrl_q[LVM_CTRL_LIN_BIT];
    wire logic [1:0] chan_sel = ctrl_q[LVM_CTRL_CH_LSB +: 2];

    // channel mux
    wire logic [15:0] sel_sample = (chan_sel == LVM_CH1) ? I_PCM_CH1 :
                                   (chan_sel == LVM_CH2) ? I_PCM_CH2 :
                                   (chan_sel == LVM_CH3) ? I_PCM_CH3 : I_PCM_CH4;

    // read data select; reserved control bits read zero
    assign rd_data_d = rd_lo_w ? {res_lo_q, ready_q} :
                       rd_hi_w ? res_hi_q :
                       rd_win_w ? win_q :
                       rd_ctrl_w ? {4'h0, ctrl_q} : 8'h00;

    // ready: a new result in the same cycle as the high-byte read wins
    assign ready_d = acc_done || (ready_q && !rd_hi_w);

    // 8 khz frame tick from the system clock
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            frame_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (frame_cnt_q == LVM_FRAME_LAST);
            if (frame_cnt_q == LVM_FRAME_LAST) begin
                frame_cnt_q <= '0;
            end else begin
                frame_cnt_q <= LVM_FRAME_CNT_W'(frame_cnt_q + 1'b1);
            end
        end
    end

    // writable registers; result bytes have no write path
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ctrl_q <= LVM_CTRL_RST;
            win_q <= LVM_WIN_RST;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= I_WR_DATA[LVM_CTRL_W-1:0];
            end
            if (wr_win_w) begin
                win_q <= I_WR_DATA;
            end
        end
    end

    // result bytes load together from one finished window
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            res_lo_q <= LVM_RES_LO_RST[7:1];
            res_hi_q <= LVM_RES_HI_RST;
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
            if (acc_done) begin
                res_hi_q <= acc_result[15:8];
                res_lo_q <= acc_result[7:1];
            end
        end
    end

    // read answer one cycle after the command; unknown codes get no answer
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            O_RD_VALID <= 1'b0;
            O_RD_DATA <= 8'h00;
        end else begin
            O_RD_VALID <= rd_any_w;
            if (rd_any_w) begin
                O_RD_DATA <= rd_data_d;
            end
        end
    end

    // window engine; bit 0 of the linear result is sacrificed to the ready flag
    lvm_window_acc u_acc (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_enable(meter_on),
        .i_linear(linear_sel),
        .i_win_count(win_q),
        .i_tick(tick_q),
        .i_sample(sel_sample),
        .o_done(acc_done),
        .o_result(acc_result)
    );

    // spacing monitor for the frame tick, kept apart from the tick counter
    logic [LVM_FRAME_CNT_W-1:0] gap_mon_q;
    logic tick_seen_q;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            gap_mon_q <= '0;
            tick_seen_q <= 1'b0;
        end else if (tick_q) begin
            gap_mon_q <= '0;
            tick_seen_q <= 1'b1;
        end else begin
            gap_mon_q <= LVM_FRAME_CNT_W'(gap_mon_q + 1'b1);
        end
    end

    default clocking lvm_cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    chk_reset_results_zero: assert property (
        $fell(I_RST) |-> res_lo_q == 7'h00 && res_hi_q == 8'h00 && !ready_q)
        else $error("result bytes not zero after reset");

    chk_hi_reset_read: assert property (
        $past(I_RST, 2) && rd_hi_w && !acc_done |=> O_RD_VALID && O_RD_DATA == 8'h00)
        else $error("high byte not zero on first read after reset");

    chk_ready_after_result: assert property (
        acc_done |=> ready_q)
        else $error("ready bit not set after a result");

    chk_ready_on_low_read: assert property (
        rd_lo_w |=> O_RD_VALID && O_RD_DATA[0] == $past(ready_q))
        else $error("low byte bit 0 does not show ready");

    chk_ready_clear_hi: assert property (
        rd_hi_w && !acc_done |=> !ready_q)
        else $error("ready bit not cleared by high-byte read");

    chk_ready_holds: assert property (
        ready_q && !rd_hi_w && !acc_done |=> ready_q)
        else $error("ready bit lost without a high-byte read");

    chk_meter_off_quiet: assert property (
        !meter_on ##1 !meter_on |-> !acc_done)
        else $error("result produced while the meter is off");

    chk_message_mode: assert property (
        acc_done && !linear_sel && $past(linear_sel) == linear_sel
        |=> res_lo_q == 7'h00 && res_hi_q == $past(acc_result[15:8]))
        else $error("message mode did not place the code in the high byte");

    chk_linear_both_bytes: assert property (
        acc_done |=> {res_hi_q, res_lo_q} == $past(acc_result[15:1]))
        else $error("linear result not placed across both bytes");

    chk_ctrl_layout: assert property (
        rd_ctrl_w |=> O_RD_DATA == {4'h0, $past(ctrl_q)})
        else $error("control register read layout wrong");

    chk_hi_read_answer: assert property (
        rd_hi_w |=> O_RD_VALID && O_RD_DATA == $past(res_hi_q))
        else $error("high byte read answer wrong");

    chk_result_no_write: assert property (
        I_CMD_VALID && I_CMD[6:0] == LVM_CMD_RD_RES_HI[6:0] && !acc_done
        |=> $stable(res_hi_q) && $stable(res_lo_q))
        else $error("a command changed the result bytes");

    chk_win_write_read: assert property (
        wr_win_w |=> win_q == $past(I_WR_DATA))
        else $error("window count write not read back");

    chk_ctrl_write: assert property (
        wr_ctrl_w |=> ctrl_q == $past(I_WR_DATA[3:0]))
        else $error("control write not stored");

    chk_channel_pick: assert property (
        tick_q && $past(meter_on) && meter_on && !linear_sel && chan_sel == LVM_CH3
        |-> ##2 res_hi_q == $past(I_PCM_CH3[7:0], 2))
        else $error("channel select picked the wrong source");

    chk_channel_one: assert property (
        tick_q && $past(meter_on) && meter_on && !linear_sel && chan_sel == LVM_CH1
        |-> ##2 res_hi_q == $past(I_PCM_CH1[7:0], 2))
        else $error("channel 1 code not in the high byte");

    chk_channel_two: assert property (
        tick_q && $past(meter_on) && meter_on && !linear_sel && chan_sel == LVM_CH2
        |-> ##2 res_hi_q == $past(I_PCM_CH2[7:0], 2))
        else $error("channel 2 code not in the high byte");

    chk_channel_four: assert property (
        tick_q && $past(meter_on) && meter_on && !linear_sel && chan_sel == LVM_CH4
        |-> ##2 res_hi_q == $past(I_PCM_CH4[7:0], 2))
        else $error("channel 4 code not in the high byte");

    chk_frame_spacing: assert property (
        tick_q |=> !tick_q [*8])
        else $error("frame ticks too close together");

    chk_bytes_together: assert property (
        $changed(res_hi_q) || $changed(res_lo_q) |-> $past(acc_done))
        else $error("result bytes changed outside a finished window");

    // frame tick spacing against the independent monitor
    chk_first_tick: assert property (
        tick_q && !tick_seen_q |-> gap_mon_q == LVM_FRAME_LAST + 1)
        else $error("first frame tick at the wrong cycle");

    chk_tick_period: assert property (
        tick_q && tick_seen_q |-> gap_mon_q == LVM_FRAME_LAST)
        else $error("frame tick period wrong");

    chk_tick_missing: assert property (
        !tick_q && tick_seen_q |-> gap_mon_q < LVM_FRAME_LAST)
        else $error("frame tick missing");

    // command port answers and holds
    chk_read_strobe: assert property (
        rd_any_w |=> O_RD_VALID)
        else $error("read command got no answer strobe");

    chk_write_no_answer: assert property (
        I_CMD_VALID && I_CMD[LVM_CMD_WR_BIT] |=> !O_RD_VALID)
        else $error("write command got an answer strobe");

    chk_rd_data_holds: assert property (
        !O_RD_VALID |-> $stable(O_RD_DATA))
        else $error("read data changed without an answer");

    chk_lo_read_answer: assert property (
        rd_lo_w |=> O_RD_VALID && O_RD_DATA == {$past(res_lo_q), $past(ready_q)})
        else $error("low byte read answer wrong");

    chk_win_read_answer: assert property (
        rd_win_w |=> O_RD_VALID && O_RD_DATA == $past(win_q))
        else $error("window count read answer wrong");

    chk_win_hold: assert property (
        !wr_win_w |=> $stable(win_q))
        else $error("window count changed without a write");

    chk_ctrl_hold: assert property (
        !wr_ctrl_w |=> $stable(ctrl_q))
        else $error("control changed without a write");

    chk_lo_no_write: assert property (
        I_CMD_VALID && I_CMD[6:0] == LVM_CMD_RD_RES_LO[6:0] && !acc_done
        |=> $stable(res_lo_q) && $stable(res_hi_q))
        else $error("a low byte command changed the result bytes");

    // result contents and the ready flag
    chk_ready_needs_result: assert property (
        !ready_q && !acc_done |=> !ready_q)
        else $error("ready bit set without a result");

    chk_message_low_zero: assert property (
        acc_done && !$past(linear_sel) |=> res_lo_q == 7'h00)
        else $error("message mode left data in the low byte");

    chk_linear_direct: assert property (
        tick_q && $past(meter_on) && meter_on && linear_sel && win_q == 8'h00
        |-> ##2 {res_hi_q, res_lo_q} == $past(sel_sample[15:1], 2))
        else $error("direct linear copy did not reach both bytes");

    chk_off_keeps_result: assert property (
        !meter_on && !$past(meter_on) |=> $stable(res_hi_q) && $stable(res_lo_q))
        else $error("result changed while the meter is off");

endmodule

// ==== rtl/lvm_pkg.sv ====
// shared constants for the pcm level meter
package lvm_pkg;

    // command codes; bit 7 of the command byte selects write
    localparam logic [7:0] LVM_CMD_RD_RES_LO = 8'h31;
    localparam logic [7:0] LVM_CMD_RD_RES_HI = 8'h32;
    localparam logic [7:0] LVM_CMD_RD_WIN = 8'h33;
    localparam logic [7:0] LVM_CMD_WR_WIN = 8'hB3;
    localparam logic [7:0] LVM_CMD_RD_CTRL = 8'h34;
    localparam logic [7:0] LVM_CMD_WR_CTRL = 8'hB4;
    localparam int LVM_CMD_WR_BIT = 7;

    // meter_control field positions
    localparam int LVM_CTRL_ON_BIT = 3;
    localparam int LVM_CTRL_LIN_BIT = 2;
    localparam int LVM_CTRL_CH_LSB = 0;
    localparam int LVM_CTRL_W = 4;

    // reset values
    localparam logic [7:0] LVM_RES_LO_RST = 8'h00;
    localparam logic [7:0] LVM_RES_HI_RST = 8'h00;
    localparam logic [7:0] LVM_WIN_RST = 8'h00;
    localparam logic [3:0] LVM_CTRL_RST = 4'h0;

    // channel select codes
    localparam logic [1:0] LVM_CH1 = 2'h0;
    localparam logic [1:0] LVM_CH2 = 2'h1;
    localparam logic [1:0] LVM_CH3 = 2'h2;
    localparam logic [1:0] LVM_CH4 = 2'h3;

    // frame timing: 125 us frames on a 40 ns clock
    localparam int LVM_FRAME_TIME_NS = 125000;
    localparam int LVM_CLK_PERIOD_NS = 40;
    localparam int LVM_FRAME_CYCLES = LVM_FRAME_TIME_NS / LVM_CLK_PERIOD_NS;
    localparam int LVM_FRAME_CNT_W = 12;
    localparam logic [11:0] LVM_FRAME_LAST = 12'(LVM_FRAME_CYCLES - 1);

    // largest positive magnitude of a 16-bit sample
    localparam logic [15:0] LVM_MAG_MAX = 16'h7FFF;

    // window engine states
    typedef enum logic [0:0] {
        LVM_IDLE = 1'b0,
        LVM_RUN = 1'b1
    } lvm_state_t;

endpackage

// ==== rtl/lvm_window_acc.sv ====
`timescale 1ns/1ns
// window engine: peak magnitude over n frames, or direct copy
module lvm_window_acc
    import lvm_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_enable,
    input wire logic i_linear,
    input wire logic [7:0] i_win_count,
    // frame tick and sample of the selected channel
    input wire logic i_tick,
    input wire logic [15:0] i_sample,
    // finished result
    output logic o_done,
    output logic [15:0] o_result
);

    // magnitude with saturation, so -32768 does not wrap to itself
    function automatic logic [15:0] lvm_mag(input logic [15:0] s);
        logic [15:0] neg;
        neg = 16'(~s + 16'h0001);
        if (!s[15]) begin
            lvm_mag = s;
        end else if (neg[15]) begin
            lvm_mag = LVM_MAG_MAX;
        end else begin
            lvm_mag = neg;
        end
    endfunction

    lvm_state_t state_q;
    lvm_state_t state_d;
    logic [7:0] cnt_q;
    logic [15:0] peak_q;

    // decode of the current frame's work
    wire logic direct_w = (i_win_count == 8'h00) || !i_linear;
    wire logic [15:0] mag_w = lvm_mag(i_sample);
    wire logic [15:0] max_w = (mag_w > peak_q) ? mag_w : peak_q;
    // a count lowered mid-window ends it now rather than after a full wrap
    wire logic last_w = (cnt_q >= 8'(i_win_count - 8'h01));
    wire logic act_w = (state_q == LVM_RUN) && i_tick;
    wire logic [15:0] direct_val_w = i_linear ? i_sample : {i_sample[7:0], 8'h00};

    // state: meter off parks the engine and drops a partial window
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LVM_IDLE: begin
                if (i_enable) begin
                    state_d = LVM_RUN;
                end
            end
            LVM_RUN: begin
                if (!i_enable) begin
                    state_d = LVM_IDLE;
                end
            end
        endcase
    end

    // window counter and peak hold; a new window starts right after one ends
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= LVM_IDLE;
            cnt_q <= 8'h00;
            peak_q <= 16'h0000;
            o_done <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            state_q <= state_d;
            o_done <= act_w && i_enable && (direct_w || last_w);
            if (state_q != LVM_RUN || !i_enable) begin
                cnt_q <= 8'h00;
                peak_q <= 16'h0000;
            end else if (act_w && direct_w) begin
                o_result <= direct_val_w;
                cnt_q <= 8'h00;
            end else if (act_w && last_w) begin
                o_result <= max_w;
                cnt_q <= 8'h00;
                peak_q <= 16'h0000;
            end else if (act_w) begin
                cnt_q <= 8'(cnt_q + 8'h01);
                peak_q <= max_w;
            end
        end
    end

    default clocking lvm_acc_cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_direct_each_frame: assert property (
        act_w && i_enable && i_win_count == 8'h00 |=> o_done)
        else $error("direct copy did not finish on the frame tick");

    chk_window_length: assert property (
        act_w && i_enable && i_linear && i_win_count != 8'h00 && !last_w |=> !o_done)
        else $error("window ended before its frame count");

endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ns
module tb;
    import lvm_pkg::*;
    logic clk;
    logic rst;
    logic cmd_valid;
    logic [7:0] cmd;
    logic [7:0] wr_data;
    logic [15:0] pcm [4];
    logic rd_valid;
    logic [7:0] rd_data;
    logic [7:0] tmp;
    int error_cnt;
    int cmp_count;
    int gap;
    time t_first;

    lvm_meter dut (
        .I_CLK_SYS(clk),
        .I_RST(rst),
        .I_CMD_VALID(cmd_valid),
        .I_CMD(cmd),
        .I_WR_DATA(wr_data),
        .I_PCM_CH1(pcm[0]),
        .I_PCM_CH2(pcm[1]),
        .I_PCM_CH3(pcm[2]),
        .I_PCM_CH4(pcm[3]),
        .O_RD_VALID(rd_valid),
        .O_RD_DATA(rd_data)
    );

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // single comparison point
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // read: answer strobe is registered by the taking edge and checked half a cycle after it
    task automatic reg_read(input logic [7:0] code, output logic [7:0] val);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = code;
        @(negedge clk);
        cmd_valid = 1'b0;
        check("read strobe", {15'h0000, rd_valid}, 16'h0001);
        val = rd_data;
    endtask

    // write: no answer strobe may follow, also for refused codes
    task automatic reg_write(input logic [7:0] code, input logic [7:0] val);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = code;
        wr_data = val;
        @(negedge clk);
        cmd_valid = 1'b0;
        check("write strobe", {15'h0000, rd_valid}, 16'h0000);
    endtask

    task automatic expect_rd(input logic [7:0] code, input logic [7:0] exp, input string what);
        logic [7:0] v;
        reg_read(code, v);
        check(what, {8'h00, v}, {8'h00, exp});
    endtask

    // poll ready; bounded so a dead engine cannot hang the run
    task automatic wait_ready;
        logic [7:0] v;
        int n;
        v = 8'h00;
        for (n = 0; n < 6000; n++) begin
            reg_read(LVM_CMD_RD_RES_LO, v);
            if (v[0] === 1'b1) begin
                break;
            end
        end
        check("ready flag", {15'h0000, v[0]}, 16'h0001);
        if (v[0] !== 1'b1) begin
            results();
        end
    endtask

    // two passes so a result from the old settings is never taken
    task automatic fresh;
        logic [7:0] v;
        reg_read(LVM_CMD_RD_RES_HI, v);
        wait_ready();
        reg_read(LVM_CMD_RD_RES_HI, v);
        wait_ready();
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = 8'h00;
        wr_data = 8'h00;
        pcm = '{16'h5A11, 16'h6B22, 16'h7C33, 16'h8D44};
        error_cnt = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        expect_rd(LVM_CMD_RD_RES_HI, 8'h00, "high first");
        // a whole frame with the meter off must leave the reset values
        repeat (3300) @(negedge clk);
        expect_rd(LVM_CMD_RD_RES_LO, 8'h00, "low reset");
        expect_rd(LVM_CMD_RD_RES_HI, 8'h00, "high reset");
        expect_rd(LVM_CMD_RD_WIN, 8'h00, "count reset");
        expect_rd(LVM_CMD_RD_CTRL, 8'h00, "ctrl reset");
        // register access, reserved bits and refused writes
        reg_write(LVM_CMD_WR_WIN, 8'hA5);
        expect_rd(LVM_CMD_RD_WIN, 8'hA5, "count rw");
        reg_write(LVM_CMD_WR_CTRL, 8'hF3);
        expect_rd(LVM_CMD_RD_CTRL, 8'h03, "ctrl rw");
        reg_write(8'hB1, 8'hFF);
        reg_write(8'hB2, 8'hFF);
        expect_rd(LVM_CMD_RD_RES_LO, 8'h00, "low no write");
        expect_rd(LVM_CMD_RD_RES_HI, 8'h00, "high no write");
        // message mode on every channel; window count must not matter
        for (int ch = 0; ch < 4; ch++) begin
            reg_write(LVM_CMD_WR_CTRL, 8'h08 | 8'(ch));
            fresh();
            expect_rd(LVM_CMD_RD_RES_LO, 8'h01, "msg low");
            expect_rd(LVM_CMD_RD_RES_HI, pcm[ch][7:0], "msg high");
            expect_rd(LVM_CMD_RD_RES_LO, 8'h00, "ready cleared");
        end
        // linear, window zero: raw sample straight through
        pcm[1] = 16'h1234;
        reg_write(LVM_CMD_WR_WIN, 8'h00);
        reg_write(LVM_CMD_WR_CTRL, 8'h0D);
        fresh();
        expect_rd(LVM_CMD_RD_RES_LO, 8'h35, "raw low");
        expect_rd(LVM_CMD_RD_RES_HI, 8'h12, "raw high");
        // linear, three frames, most negative sample saturates
        pcm[0] = 16'h8000;
        reg_write(LVM_CMD_WR_WIN, 8'h03);
        reg_write(LVM_CMD_WR_CTRL, 8'h0C);
        fresh();
        t_first = $time;
        expect_rd(LVM_CMD_RD_RES_LO, 8'hFF, "peak low");
        expect_rd(LVM_CMD_RD_RES_HI, 8'h7F, "peak high");
        wait_ready();
        gap = int'(($time - t_first) / 40);
        check("window length", {15'h0000, gap >= 9371 && gap <= 9379}, 16'h0001);
        // meter off: ready clear, result kept
        reg_write(LVM_CMD_WR_CTRL, 8'h04);
        reg_read(LVM_CMD_RD_RES_HI, tmp);
        repeat (3300) @(negedge clk);
        expect_rd(LVM_CMD_RD_RES_LO, 8'hFE, "off low");
        expect_rd(LVM_CMD_RD_RES_HI, 8'h7F, "off high");
        results();
    end
endmodule
